/* design/fllcg_defines.svh */
// Offsets, field positions, reset values and timing counts of the clock block.
// Assumes a byte-wide register port with 8-bit addresses.
`ifndef FLLCG_DEFINES_SVH
`define FLLCG_DEFINES_SVH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define FLLCG_ADDR_INTEG_LO   8'h50
`define FLLCG_ADDR_INTEG_HI   8'h51
`define FLLCG_ADDR_MULT       8'h52
`define FLLCG_ADDR_CBUF       8'h53
`define FLLCG_ADDR_STAT       8'h54
`define FLLCG_ADDR_IFLAG      8'h58
`define FLLCG_ADDR_IENA       8'h59

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define FLLCG_MULT_RST        8'h1f
`define FLLCG_INTEG_RST       10'h000
`define FLLCG_RANGE_RST       3'h0

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define FLLCG_MULT_N_MSB      6
`define FLLCG_MULT_MODDIS_BIT 7
`define FLLCG_LO_RANGE_LSB    2
`define FLLCG_LO_RANGE_MSB    4
`define FLLCG_FAULT_BIT       1
`define FLLCG_STAT_FREEZE_BIT 0
`define FLLCG_STAT_XSTOP_BIT  1
`define FLLCG_CB_ON_BIT       0
`define FLLCG_CB_SEL_LO_BIT   1
`define FLLCG_CB_SEL_HI_BIT   2

// ---------------------------------------------------------------
// Limits and timing
// ---------------------------------------------------------------
`define FLLCG_TAP_TOP         5'h1c
`define FLLCG_INTEG_MAX       10'h3ff
`define FLLCG_CNT_MAX         12'hfff
`define FLLCG_CLK_PERIOD_NS   20
`define FLLCG_AUX_TIMEOUT_NS  61000
`define FLLCG_AUX_TIMEOUT_CYC (`FLLCG_AUX_TIMEOUT_NS / `FLLCG_CLK_PERIOD_NS)

`endif

/* design/fllcg_pkg.sv */
// Types shared by the clock block.
// Assumes the defines header is compiled alongside.
package fllcg_pkg;

    // ---------------------------------------------------------------
    // Clock buffer source select
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        FLLCG_CB_AUX    = 2'b00,
        FLLCG_CB_AUX_D2 = 2'b01,
        FLLCG_CB_AUX_D4 = 2'b10,
        FLLCG_CB_MAIN   = 2'b11
    } fllcg_cbsel_e;

    typedef logic [4:0] fllcg_tap_t;
    typedef logic [9:0] fllcg_integ_t;

endpackage

/* design/fllcg_top.sv */
// Frequency-locked loop clock generator: integrator, modulator, fault flag.
// Assumes aux and main clock arrive as asynchronous pins; NMI grant is local.
//
// Functional notes
// - Lock main to (N+1) times aux
// - Reset loads N with 31
// - Compare aux with main/(N+1), steer integrator
// - Integrator moves one count per aux period
// - 1024 settings drive oscillator directly
// - Upper five bits tap, lower five pattern
// - Tap codes 28 to 31 equal top
// - Modulator mixes tap with next higher
// - Range bits select 1x to 4x nominal
// - Loop freeze holds integrator
// - Modulation disable keeps loop, stops mixing
// - Crystal runs from reset; stop holds aux high
// - Missing aux keeps counting down
// - Fault on tap 0 or 28 to 31
// - Fault flag held; only software clears
// - Enabled fault requests NMI; grant clears enable
// - Main clock runs even at lowest tap
// - Buffer outputs main, aux, aux/2, aux/4, off
// - Reset clears integrator registers
// - Fault flag and enable at bit 1
// - Buffer drives only when on; select order
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "fllcg_defines.svh"

module fllcg_top (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_we_i,
    input  wire logic       reg_re_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       crystal_in_i,
    input  wire logic       main_clk_i,
    input  wire logic       nmi_grant_i,
    output logic            aux_clk_o,
    output logic            crystal_stop_o,
    output logic      [4:0] dco_tap_o,
    output logic      [1:0] dco_range_o,
    output logic            dco_run_o,
    output logic            nmi_req_o,
    output logic            osc_fault_flag_o,
    output logic            buffered_clock_out_o,
    output logic            buffered_clock_out_oe_o
);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic       [7:0]         mult_r;
    logic       [9:0]         integ_r;
    logic       [9:0]         integ_nxt;
    logic       [2:0]         range_r;
    logic                     loop_freeze_r;
    logic                     crystal_stop_r;
    logic                     osc_fault_flag_r;
    logic                     osc_fault_enable_r;
    logic                     clock_buffer_on_r;
    logic                     clock_buffer_sel_hi_r;
    logic                     clock_buffer_sel_lo_r;
    logic       [2:0]         aux_sync_r;
    logic       [2:0]         main_sync_r;
    logic                     aux_lvl_r;
    logic                     aux_lvl_nxt;
    logic                     main_lvl_r;
    logic                     main_lvl_nxt;
    logic                     aux_edge;
    logic                     main_edge;
    logic       [11:0]        cnt_r;
    logic       [11:0]        target;
    logic       [11:0]        wd_r;
    logic                     wd_expire;
    logic       [1:0]         aux_div_r;
    logic                     step_up;
    logic                     step_dn;
    logic                     osc_fault;
    fllcg_pkg::fllcg_tap_t    tap;
    fllcg_pkg::fllcg_tap_t    tap_clamped;
    fllcg_pkg::fllcg_tap_t    tap_nxt;
    fllcg_pkg::fllcg_tap_t    pattern;
    fllcg_pkg::fllcg_tap_t    slot_rev;
    logic                     mix_up;
    fllcg_pkg::fllcg_cbsel_e  cb_sel;
    logic                     cb_nxt;
    logic       [7:0]         rdata_nxt;
    logic                     wr_lo;
    logic                     wr_hi;
    logic                     wr_mult;
    logic                     wr_cbuf;
    logic                     wr_stat;
    logic                     wr_iflag;
    logic                     wr_iena;

    // ---------------------------------------------------------------
    // Write decode
    // ---------------------------------------------------------------
    assign wr_lo    = reg_we_i && (reg_addr_i == `FLLCG_ADDR_INTEG_LO);
    assign wr_hi    = reg_we_i && (reg_addr_i == `FLLCG_ADDR_INTEG_HI);
    assign wr_mult  = reg_we_i && (reg_addr_i == `FLLCG_ADDR_MULT);
    assign wr_cbuf  = reg_we_i && (reg_addr_i == `FLLCG_ADDR_CBUF);
    assign wr_stat  = reg_we_i && (reg_addr_i == `FLLCG_ADDR_STAT);
    assign wr_iflag = reg_we_i && (reg_addr_i == `FLLCG_ADDR_IFLAG);
    assign wr_iena  = reg_we_i && (reg_addr_i == `FLLCG_ADDR_IENA);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aux_sync_r  <= 3'h0;
            main_sync_r <= 3'h0;
        end else begin
            aux_sync_r  <= {aux_sync_r[1:0], crystal_in_i};
            main_sync_r <= {main_sync_r[1:0], main_clk_i};
        end
    end

    // Level accepted once second and third stages agree
    assign aux_lvl_nxt  = (aux_sync_r[1] == aux_sync_r[2]) ?
                          aux_sync_r[2] : aux_lvl_r;
    assign main_lvl_nxt = (main_sync_r[1] == main_sync_r[2]) ?
                          main_sync_r[2] : main_lvl_r;

    assign aux_edge  = aux_lvl_nxt && !aux_lvl_r;
    assign main_edge = main_lvl_nxt && !main_lvl_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aux_lvl_r  <= 1'b0;
            main_lvl_r <= 1'b0;
        end else begin
            aux_lvl_r  <= aux_lvl_nxt;
            main_lvl_r <= main_lvl_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Main clock edges per aux period
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 12'h000;
        end else if (aux_edge) begin
            cnt_r <= {11'h000, main_edge};
        end else if (main_edge && (cnt_r != `FLLCG_CNT_MAX)) begin
            cnt_r <= cnt_r + 12'h001;
        end
    end

    // Missing-aux watchdog
    assign wd_expire = (wd_r == 12'(`FLLCG_AUX_TIMEOUT_CYC - 1));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wd_r <= 12'h000;
        end else if (aux_edge || wd_expire) begin
            wd_r <= 12'h000;
        end else begin
            wd_r <= wd_r + 12'h001;
        end
    end

    // ---------------------------------------------------------------
    // Frequency integrator
    // ---------------------------------------------------------------
    assign target = {5'h00, mult_r[`FLLCG_MULT_N_MSB:0]} + 12'h001;

    // Too many main edges means too fast: count down
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if (!loop_freeze_r) begin
            if (aux_edge) begin
                step_dn = (cnt_r > target);
                step_up = !(cnt_r > target);
            end else if (wd_expire) begin
                step_dn = 1'b1;
            end
        end
    end

    always_comb begin
        integ_nxt = integ_r;
        if (step_up && (integ_r != `FLLCG_INTEG_MAX)) begin
            integ_nxt = integ_r + 10'h001;
        end else if (step_dn && (integ_r != 10'h000)) begin
            integ_nxt = integ_r - 10'h001;
        end
        if (wr_lo) begin
            integ_nxt[1:0] = reg_wdata_i[1:0];
        end
        if (wr_hi) begin
            integ_nxt[9:2] = reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            integ_r <= `FLLCG_INTEG_RST;
        end else begin
            integ_r <= integ_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mult_r <= `FLLCG_MULT_RST;
        end else if (wr_mult) begin
            mult_r <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            range_r <= `FLLCG_RANGE_RST;
        end else if (wr_lo) begin
            range_r <= reg_wdata_i[`FLLCG_LO_RANGE_MSB:`FLLCG_LO_RANGE_LSB];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            loop_freeze_r  <= 1'b0;
            crystal_stop_r <= 1'b0;
        end else if (wr_stat) begin
            loop_freeze_r  <= reg_wdata_i[`FLLCG_STAT_FREEZE_BIT];
            crystal_stop_r <= reg_wdata_i[`FLLCG_STAT_XSTOP_BIT];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clock_buffer_on_r     <= 1'b0;
            clock_buffer_sel_hi_r <= 1'b0;
            clock_buffer_sel_lo_r <= 1'b0;
        end else if (wr_cbuf) begin
            clock_buffer_on_r     <= reg_wdata_i[`FLLCG_CB_ON_BIT];
            clock_buffer_sel_hi_r <= reg_wdata_i[`FLLCG_CB_SEL_HI_BIT];
            clock_buffer_sel_lo_r <= reg_wdata_i[`FLLCG_CB_SEL_LO_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Oscillator fault flag and enable
    // ---------------------------------------------------------------
    assign tap       = integ_r[9:5];
    assign osc_fault = (tap == 5'h00) || (tap >= `FLLCG_TAP_TOP);

    // Fault set wins over a software clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_fault_flag_r <= 1'b0;
        end else if (osc_fault) begin
            osc_fault_flag_r <= 1'b1;
        end else if (wr_iflag) begin
            osc_fault_flag_r <= reg_wdata_i[`FLLCG_FAULT_BIT];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_fault_enable_r <= 1'b0;
        end else if (nmi_grant_i) begin
            osc_fault_enable_r <= 1'b0;
        end else if (wr_iena) begin
            osc_fault_enable_r <= reg_wdata_i[`FLLCG_FAULT_BIT];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nmi_req_o        <= 1'b0;
            osc_fault_flag_o <= 1'b0;
        end else begin
            nmi_req_o        <= osc_fault_flag_r && osc_fault_enable_r
                                && !nmi_grant_i;
            osc_fault_flag_o <= osc_fault_flag_r;
        end
    end

    // ---------------------------------------------------------------
    // Tap select and modulator
    // ---------------------------------------------------------------
    assign tap_clamped = (tap >= `FLLCG_TAP_TOP) ? `FLLCG_TAP_TOP : tap;
    assign pattern     = {integ_r[4:2], integ_r[1:0]};
    assign slot_rev    = {cnt_r[0], cnt_r[1], cnt_r[2], cnt_r[3], cnt_r[4]};

    // Bit-reversed slot spreads the hops over the period
    assign mix_up = !mult_r[`FLLCG_MULT_MODDIS_BIT]
                    && (slot_rev < pattern);

    always_comb begin
        tap_nxt = tap_clamped;
        if (mix_up && (tap_clamped != `FLLCG_TAP_TOP)) begin
            tap_nxt = tap_clamped + 5'h01;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dco_tap_o   <= 5'h00;
            dco_range_o <= 2'h0;
            dco_run_o   <= 1'b1;
        end else begin
            dco_tap_o   <= tap_nxt;
            dco_run_o   <= 1'b1;
            dco_range_o <= range_r[2] ? 2'h3 :
                           (range_r[1] ? 2'h2 : {1'b0, range_r[0]});
        end
    end

    // ---------------------------------------------------------------
    // Aux clock output and dividers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aux_div_r <= 2'h0;
        end else if (aux_edge) begin
            aux_div_r <= aux_div_r + 2'h1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aux_clk_o      <= 1'b0;
            crystal_stop_o <= 1'b0;
        end else begin
            aux_clk_o      <= crystal_stop_r ? 1'b1 : aux_lvl_nxt;
            crystal_stop_o <= crystal_stop_r;
        end
    end

    // ---------------------------------------------------------------
    // Buffered clock output
    // ---------------------------------------------------------------
    assign cb_sel = fllcg_pkg::fllcg_cbsel_e'(
                        {clock_buffer_sel_hi_r, clock_buffer_sel_lo_r});

    always_comb begin
        case (cb_sel)
            fllcg_pkg::FLLCG_CB_AUX:    cb_nxt = aux_lvl_nxt;
            fllcg_pkg::FLLCG_CB_AUX_D2: cb_nxt = aux_div_r[0];
            fllcg_pkg::FLLCG_CB_AUX_D4: cb_nxt = aux_div_r[1];
            fllcg_pkg::FLLCG_CB_MAIN:   cb_nxt = main_lvl_nxt;
            default:                    cb_nxt = 1'b0;
        endcase
        if (crystal_stop_r && (cb_sel != fllcg_pkg::FLLCG_CB_MAIN)) begin
            cb_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            buffered_clock_out_o    <= 1'b0;
            buffered_clock_out_oe_o <= 1'b0;
        end else begin
            buffered_clock_out_o    <= clock_buffer_on_r && cb_nxt;
            buffered_clock_out_oe_o <= clock_buffer_on_r;
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_comb begin
        case (reg_addr_i)
            `FLLCG_ADDR_INTEG_LO: rdata_nxt = {3'h0, range_r, integ_r[1:0]};
            `FLLCG_ADDR_INTEG_HI: rdata_nxt = integ_r[9:2];
            `FLLCG_ADDR_MULT:     rdata_nxt = mult_r;
            `FLLCG_ADDR_STAT: begin
                rdata_nxt = {6'h00, crystal_stop_r, loop_freeze_r};
            end
            `FLLCG_ADDR_IFLAG: begin
                rdata_nxt = {6'h00, osc_fault_flag_r, 1'b0};
            end
            `FLLCG_ADDR_IENA: rdata_nxt = {6'h00, osc_fault_enable_r, 1'b0};
            default:          rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= reg_re_i ? rdata_nxt : 8'h00;
        end
    end

endmodule

/* test/fllcg_properties.sv */
// Port checker for the clock block.
// Assumes it is bound to fllcg_top on one clock domain.
`timescale 1ns/10ps
module fllcg_chk (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_we_i,
    input wire logic       reg_re_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       nmi_grant_i,
    input wire logic       aux_clk_o,
    input wire logic       crystal_stop_o,
    input wire logic [4:0] dco_tap_o,
    input wire logic [1:0] dco_range_o,
    input wire logic       dco_run_o,
    input wire logic       nmi_req_o,
    input wire logic       osc_fault_flag_o,
    input wire logic       buffered_clock_out_o,
    input wire logic       buffered_clock_out_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // --------------------------------
    // Assertions and cover points
    // --------------------------------
    a_run_kept: assert property (dco_run_o)
        else $error("main clock run dropped");
    a_aux_high: assert property (crystal_stop_o[*4] |-> aux_clk_o)
        else $error("aux clock not held high while stopped");
    a_tap_top: assert property (dco_tap_o <= 5'h1c)
        else $error("tap above top setting");
    a_grant_drop: assert property (nmi_grant_i |=> !nmi_req_o)
        else $error("nmi request kept after grant");
    a_nmi_cause: assert property (nmi_req_o |-> osc_fault_flag_o)
        else $error("nmi request without fault flag");
    a_flag_kept: assert property ($fell(osc_fault_flag_o) |->
        $past(reg_we_i, 2) && $past(reg_addr_i, 2) == 8'h58)
        else $error("fault flag cleared without a write");
    a_cbuf_wo: assert property ($past(reg_re_i) &&
        $past(reg_addr_i) == 8'h53 |-> reg_rdata_o == 8'h00)
        else $error("buffer control read not zero");
    a_oe_on: assert property (reg_we_i && reg_addr_i == 8'h53 &&
        reg_wdata_i[0] |-> ##[1:2] buffered_clock_out_oe_o)
        else $error("buffer enable not followed");
    a_out_off: assert property (
        (!buffered_clock_out_oe_o)[*2] |-> !buffered_clock_out_o)
        else $error("buffer output active while off");
    a_stop_on: assert property (reg_we_i && reg_addr_i == 8'h54 &&
        reg_wdata_i[1] |-> ##[1:2] crystal_stop_o)
        else $error("crystal stop not followed");
    a_range_top: assert property (reg_we_i && reg_addr_i == 8'h50 &&
        reg_wdata_i[4] |-> ##[1:2] dco_range_o == 2'd3)
        else $error("range not four times nominal");
    c_nmi: cover property (nmi_req_o);
    c_flag: cover property ($fell(osc_fault_flag_o));
    c_oe: cover property (buffered_clock_out_oe_o);
    c_stop: cover property (crystal_stop_o);
endmodule

bind fllcg_top fllcg_chk u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .nmi_grant_i(nmi_grant_i),
    .aux_clk_o(aux_clk_o), .crystal_stop_o(crystal_stop_o),
    .dco_tap_o(dco_tap_o), .dco_range_o(dco_range_o),
    .dco_run_o(dco_run_o), .nmi_req_o(nmi_req_o),
    .osc_fault_flag_o(osc_fault_flag_o),
    .buffered_clock_out_o(buffered_clock_out_o),
    .buffered_clock_out_oe_o(buffered_clock_out_oe_o)
);

/* test/fllcg_osc_model.sv */
// Crystal and tapped oscillator model facing the clock block.
// Assumes tap and crystal stop come from fllcg_top.
`timescale 1ns/10ps
module fllcg_osc_model #(
    parameter int AUX_HALF_NS = 2000
) (
    input  wire logic [4:0] dco_tap_i,
    input  wire logic       crystal_stop_i,
    input  wire logic       fail_i,
    output logic            crystal_out_o,
    output logic            main_clk_o
);
    int tap_q;
    initial begin
        crystal_out_o = 1'b0;
        forever begin
            #(AUX_HALF_NS);
            if (!crystal_stop_i && !fail_i) begin
                crystal_out_o = !crystal_out_o;
            end
        end
    end
    // Faster for higher taps up to 28, never stops
    initial begin
        main_clk_o = 1'b0;
        forever begin
            tap_q = (dco_tap_i > 5'd28) ? 28 : int'(dco_tap_i);
            #(240 - 6 * tap_q);
            main_clk_o = !main_clk_o;
        end
    end
endmodule

/* test/test_freq_locked_loop_clock_gen.sv */
// Self-checking bench for the clock block.
// Assumes fllcg_top, its bound checker and the oscillator model.
`timescale 1ns/10ps
`include "fllcg_defines.svh"
module test_freq_locked_loop_clock_gen;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_we_i = 1'b0;
    logic       reg_re_i = 1'b0;
    logic       nmi_grant_i = 1'b0;
    logic       fail = 1'b0;
    logic       crystal_in_i, main_clk_i, aux_clk_o, crystal_stop_o;
    logic [7:0] reg_rdata_o;
    logic [4:0] dco_tap_o;
    logic [1:0] dco_range_o;
    logic       dco_run_o, nmi_req_o, osc_fault_flag_o;
    logic       buffered_clock_out_o, buffered_clock_out_oe_o;
    logic [7:0] exp_q[$];
    logic       rd_pend = 1'b0;
    logic [4:0] taps[5] = '{5'd1, 5'd0, 5'd27, 5'd28, 5'd31};
    logic [7:0] v;
    int         err_total = 0;
    int         checked = 0;
    int         i;

    fllcg_top DUT (
        .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .crystal_in_i(crystal_in_i), .main_clk_i(main_clk_i),
        .nmi_grant_i(nmi_grant_i), .aux_clk_o(aux_clk_o),
        .crystal_stop_o(crystal_stop_o), .dco_tap_o(dco_tap_o),
        .dco_range_o(dco_range_o), .dco_run_o(dco_run_o),
        .nmi_req_o(nmi_req_o), .osc_fault_flag_o(osc_fault_flag_o),
        .buffered_clock_out_o(buffered_clock_out_o),
        .buffered_clock_out_oe_o(buffered_clock_out_oe_o)
    );
    fllcg_osc_model u_osc (
        .dco_tap_i(dco_tap_o), .crystal_stop_i(crystal_stop_o),
        .fail_i(fail), .crystal_out_o(crystal_in_i),
        .main_clk_o(main_clk_i)
    );

    initial forever #10 clk_i = ~clk_i;

    // --------------------------------
    // Bus tasks and checks
    // --------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        exp_q.push_back(e);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Read data watcher
    always @(posedge clk_i) begin
        if (rd_pend) begin
            chk(reg_rdata_o, exp_q.pop_front());
        end
        rd_pend <= reg_re_i;
    end

    initial begin
        #(40000 * 20);
        err_total++;
        end_of_test();
    end

    // --------------------------------
    // Tests
    // --------------------------------
    initial begin
        v = 8'($urandom(32'hc785_2257));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h52, 8'h1f);
        rd(8'h50, 8'h00);
        rd(8'h51, 8'h00);
        rd(8'h59, 8'h00);
        rd(8'h58, 8'h02);
        rd(8'h5f, 8'h00);
        rd(8'h53, 8'h00);
        $display("test reset done");
        wr(8'h54, 8'h01);
        wr(8'h52, v);
        rd(8'h52, v);
        wr(8'h51, 8'h40);
        repeat (1000) @(posedge clk_i);
        rd(8'h51, 8'h40);
        chk({3'h0, dco_tap_o}, 8'h08);
        wr(8'h51, 8'h47);
        wr(8'h50, 8'h03);
        wr(8'h52, 8'h80);
        settle(300);
        chk({3'h0, dco_tap_o}, 8'h08);
        rd(8'h50, 8'h03);
        for (i = 0; i < 5; i++) begin
            wr(8'h51, {taps[i], 3'b000});
            wr(8'h58, 8'h00);
            v = (taps[i] == 0 || taps[i] > 27) ? 8'h02 : 8'h00;
            rd(8'h58, v);
        end
        wr(8'h59, 8'h02);
        settle(3);
        chk({7'h0, nmi_req_o}, 8'h01);
        rd(8'h58, 8'h02);
        @(posedge clk_i);
        nmi_grant_i <= 1'b1;
        @(posedge clk_i);
        nmi_grant_i <= 1'b0;
        rd(8'h59, 8'h00);
        $display("test freeze and fault done");
        for (i = 0; i < 8; i++) begin
            v = 8'(i << 2);
            wr(8'h50, v);
            rd(8'h50, v);
            settle(1);
            chk({6'h0, dco_range_o},
                v[4] ? 8'h03 : v[3] ? 8'h02 : {7'h0, v[2]});
        end
        for (i = 0; i < 4; i++) begin
            wr(8'h53, 8'((i << 1) | 1));
            settle(2);
            chk({7'h0, buffered_clock_out_oe_o}, 8'h01);
            rd(8'h53, 8'h00);
        end
        wr(8'h53, 8'h00);
        settle(2);
        chk({6'h0, buffered_clock_out_oe_o,
             buffered_clock_out_o}, 8'h00);
        $display("test range and buffer done");
        wr(8'h52, 8'h7f);
        wr(8'h51, 8'hff);
        wr(8'h50, 8'h03);
        wr(8'h54, 8'h00);
        repeat (2000) @(posedge clk_i);
        rd(8'h51, 8'hff);
        rd(8'h50, 8'h03);
        chk({3'h0, dco_tap_o}, 8'h1c);
        $display("test saturation done");
        fail <= 1'b1;
        repeat (10) @(posedge clk_i);
        wr(8'h51, 8'h01);
        wr(8'h50, 8'h00);
        repeat (5 * `FLLCG_AUX_TIMEOUT_CYC + 200) @(posedge clk_i);
        rd(8'h51, 8'h00);
        rd(8'h50, 8'h00);
        fail <= 1'b0;
        wr(8'h54, 8'h02);
        settle(10);
        chk({6'h0, crystal_stop_o, aux_clk_o}, 8'h03);
        wr(8'h54, 8'h00);
        repeat (3) @(posedge clk_i);
        $display("test crystal done");
        end_of_test();
    end
endmodule
